// file: logic/fte_defs.svh
// constants for the tag and exception unit: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite register port and an 80-bit extended format
`ifndef FTE_DEFS_SVH
`define FTE_DEFS_SVH
`define FTE_OFF_CTRL 12'h000
`define FTE_OFF_STATUS 12'h004
`define FTE_OFF_IMASK 12'h008
`define FTE_OFF_TAGW 12'h00c
`define FTE_OFF_LAST 12'h010
// exception bit positions, shared by ctrl masks, status and imask
`define FTE_EX_INV 0
`define FTE_EX_DEN 1
`define FTE_EX_OVF 2
`define FTE_EX_UNF 3
`define FTE_EX_PRE 4
`define FTE_PC_LSB 8
`define FTE_RC_LSB 10
`define FTE_CTRL_RST 32'h0000_031f
`define FTE_RC_CHOP 2'h3
`define FTE_PC_EXT 2'h3
`define FTE_TAG_VALID 2'h0
`define FTE_TAG_ZERO 2'h1
`define FTE_TAG_SPECIAL 2'h2
`define FTE_TAG_EMPTY 2'h3
`endif

// file: logic/fte_pkg.sv
// types for the tag and exception unit
// assumes fte_defs.svh holds the numeric constants
package fte_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ARITH = 4'h1,
        OP_TRANSC = 4'h2,
        OP_EXTRACT = 4'h3,
        OP_COMPARE = 4'h4,
        OP_INT_STORE = 4'h5,
        OP_BCD_STORE = 4'h6,
        OP_ENV_LOAD = 4'h7,
        OP_ENV_STORE = 4'h8
    } fte_op_t;
    typedef enum logic [2:0] {
        RES_NORMAL = 3'h0,
        RES_NONE = 3'h1,
        RES_QUIET_NAN = 3'h2,
        RES_NORMALIZE = 3'h3,
        RES_MAXFIN = 3'h4,
        RES_INF = 3'h5,
        RES_ROUNDED = 3'h6
    } fte_res_t;
    typedef enum logic [2:0] {
        TOP_NONE = 3'h0,
        TOP_INV = 3'h1,
        TOP_DEN = 3'h2,
        TOP_OVF = 3'h3,
        TOP_UNF = 3'h4,
        TOP_PRE = 3'h5
    } fte_top_t;
endpackage : fte_pkg

// file: logic/fte_classify.sv
// operand classifier: looks at an 80-bit extended value, never at a tag
// assumes sign 79, exponent 78:64, explicit integer bit 63
`include "fte_defs.svh"
module fte_classify (
    input wire logic [79:0] value,
    output logic [1:0] tag,
    output logic isSnan,
    output logic isQnan,
    output logic isDenorm,
    output logic isUnsupp
);
    logic expZero;
    logic expMax;
    logic intBit;
    logic fracZero;

    assign expZero = (value[78:64] == 15'h0000);
    assign expMax = (value[78:64] == 15'h7fff);
    assign intBit = value[63];
    assign fracZero = (value[62:0] == 63'h0);

    // unnormal, pseudo-zero, pseudo-inf and pseudo-nan lack the integer bit
    always_comb begin
        isUnsupp = !expZero && !intBit;
        isSnan = expMax && intBit && !fracZero && !value[62];
        isQnan = expMax && intBit && value[62];
        isDenorm = expZero && !(intBit == 1'b0 && fracZero);
        if (expZero && !intBit && fracZero) begin
            tag = `FTE_TAG_ZERO;
        end else if (expZero || expMax || isUnsupp) begin
            tag = `FTE_TAG_SPECIAL;
        end else begin
            tag = `FTE_TAG_VALID;
        end
    end
endmodule : fte_classify

// file: logic/fte_unit.sv
// tag word and exception decision logic of the floating-point unit
// assumes the pipeline presents one instruction per opValid cycle,
// register writes on regWrEn, and AXI4-Lite for control and status
// Summary of operation
// - A loaded tag word only marks each register empty (11) or not.
// - Operands of non-empty registers are classified from contents.
// - A stored tag word is recomputed from each non-empty register.
// - Unsupported formats, pseudo-zero and unnormal, tag as special.
// - NaN results are quiet and quiet NaN operands raise nothing outside compare and the two stores.
// - Signaling NaNs raise invalid; compare and the two stores also quiet_nan.
// - Pseudo or unnormal operands in arithmetic raise invalid.
// - With denormal masked, denormal operands are normalized.
// - Transcendental and exponent-extract raise denormal as others do.
// - Masked overflow rounding toward zero gives the largest finite.
// - Unmasked overflow also flags precision and rounds to PC or opcode.
// - Masked underflow is signaled only when tiny and inexact.
// - Unmasked underflow adjusts exponent then rounds to PC or extended.
// - Denormal priority among exceptions does not depend on its mask.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "fte_defs.svh"
module fte_unit #(
    parameter int NREG = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic regWrEn,
    input wire logic [2:0] regWrIdx,
    input wire logic [79:0] regWrData,
    input wire logic opValid,
    input wire fte_pkg::fte_op_t opCode,
    input wire logic [2:0] opRegA,
    input wire logic [2:0] opRegB,
    input wire logic opUsesB,
    input wire logic opPcControlled,
    input wire logic [1:0] opPrec,
    input wire logic [15:0] tagWordIn,
    input wire logic resOverflow,
    input wire logic resTiny,
    input wire logic resInexact,
    output logic [15:0] tagWordOut,
    output logic tagWordValid,
    output logic excValid,
    output logic [4:0] excFlags,
    output fte_pkg::fte_top_t excTop,
    output fte_pkg::fte_res_t resultSel,
    output logic [1:0] roundPrec,
    output logic expAdjust,
    output logic irq
);
    logic [79:0] stackReg [NREG];
    logic [NREG-1:0] emptyMask;
    logic [1:0] clsTag [NREG];
    logic [NREG-1:0] clsSnan, clsQnan, clsDen, clsUns;
    logic [31:0] ctrl, status, imask, lastResp;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wrGo;
    logic [15:0] liveTagWord;
    logic [4:0] next_flags;
    logic [31:0] next_status;
    logic [31:0] next_imask;
    fte_pkg::fte_top_t next_top;
    fte_pkg::fte_res_t next_res;
    logic [1:0] next_prec;
    logic next_expAdj;
    logic anySnan, anyQnan, anyDen, anyUns, isArith, isStrictNan;

    // merge write data under byte strobes
    function automatic logic [31:0] strobeMerge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction : strobeMerge

    // operand is present only when its register holds a value
    function automatic logic present(input logic [2:0] idx,
        input logic [NREG-1:0] em);
        return !em[idx];
    endfunction : present

    // one classifier per register: tags and operand classes come from data
    for (genvar g = 0; g < NREG; g++) begin : g_cls
        fte_classify u_cls (
            .value(stackReg[g]),
            .tag(clsTag[g]),
            .isSnan(clsSnan[g]),
            .isQnan(clsQnan[g]),
            .isDenorm(clsDen[g]),
            .isUnsupp(clsUns[g])
        );
        assign liveTagWord[2*g +: 2] = emptyMask[g] ? `FTE_TAG_EMPTY
            : clsTag[g];
    end

    // data registers: a pipeline write fills a register
    always_ff @(posedge clk) begin
        if (regWrEn) begin
            stackReg[regWrIdx] <= regWrData;
        end
    end

    // empty marks: a loaded tag of 11 is empty, 00/01/10 all non-empty;
    // the loaded code itself is dropped so it cannot disagree with data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            emptyMask <= '1;
        end else if (opValid && opCode == fte_pkg::OP_ENV_LOAD) begin
            for (int i = 0; i < NREG; i++) begin
                emptyMask[i] <= (tagWordIn[2*i +: 2] == `FTE_TAG_EMPTY);
            end
        end else if (regWrEn) begin
            emptyMask[regWrIdx] <= 1'b0;
        end
    end

    // tag word out on a store, rebuilt from register contents
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tagWordOut <= 16'hffff;
            tagWordValid <= 1'b0;
        end else begin
            tagWordValid <= opValid && opCode == fte_pkg::OP_ENV_STORE;
            if (opValid && opCode == fte_pkg::OP_ENV_STORE) begin
                tagWordOut <= liveTagWord;
            end
        end
    end

    // operand class summary over the one or two operands in use
    always_comb begin
        anySnan = present(opRegA, emptyMask) && clsSnan[opRegA];
        anyQnan = present(opRegA, emptyMask) && clsQnan[opRegA];
        anyDen = present(opRegA, emptyMask) && clsDen[opRegA];
        anyUns = present(opRegA, emptyMask) && clsUns[opRegA];
        if (opUsesB && present(opRegB, emptyMask)) begin
            anySnan = anySnan || clsSnan[opRegB];
            anyQnan = anyQnan || clsQnan[opRegB];
            anyDen = anyDen || clsDen[opRegB];
            anyUns = anyUns || clsUns[opRegB];
        end
        isArith = opCode inside {fte_pkg::OP_ARITH, fte_pkg::OP_TRANSC,
            fte_pkg::OP_EXTRACT, fte_pkg::OP_COMPARE,
            fte_pkg::OP_INT_STORE, fte_pkg::OP_BCD_STORE};
        isStrictNan = opCode inside {fte_pkg::OP_COMPARE,
            fte_pkg::OP_INT_STORE, fte_pkg::OP_BCD_STORE};
    end

    // exception flags and the response; masks live in ctrl
    always_comb begin
        next_flags = 5'h00;
        next_res = fte_pkg::RES_NORMAL;
        next_prec = `FTE_PC_EXT;
        next_expAdj = 1'b0;
        if (isArith) begin
            next_flags[`FTE_EX_INV] = anySnan
                || (anyQnan && isStrictNan)
                || anyUns;
            next_flags[`FTE_EX_DEN] = anyDen;
            next_flags[`FTE_EX_OVF] = resOverflow;
            next_flags[`FTE_EX_UNF] = ctrl[`FTE_EX_UNF]
                ? (resTiny && resInexact) : resTiny;
            next_flags[`FTE_EX_PRE] = resInexact
                || (resOverflow && !ctrl[`FTE_EX_OVF]);
            if (next_flags[`FTE_EX_INV]) begin
                next_res = ctrl[`FTE_EX_INV] ? fte_pkg::RES_QUIET_NAN
                    : fte_pkg::RES_NONE;
            end else if (anyQnan) begin
                next_res = fte_pkg::RES_QUIET_NAN;
            end else if (anyDen && !ctrl[`FTE_EX_DEN]) begin
                next_res = fte_pkg::RES_NONE;
            end else if (resOverflow && ctrl[`FTE_EX_OVF]) begin
                next_res = (ctrl[`FTE_RC_LSB +: 2] == `FTE_RC_CHOP)
                    ? fte_pkg::RES_MAXFIN : fte_pkg::RES_INF;
            end else if (resOverflow) begin
                next_res = fte_pkg::RES_ROUNDED;
                next_prec = opPcControlled ? ctrl[`FTE_PC_LSB +: 2]
                    : opPrec;
            end else if (resTiny && !ctrl[`FTE_EX_UNF]) begin
                next_res = fte_pkg::RES_ROUNDED;
                next_expAdj = 1'b1;
                next_prec = opPcControlled ? ctrl[`FTE_PC_LSB +: 2]
                    : `FTE_PC_EXT;
            end else if (anyDen) begin
                next_res = fte_pkg::RES_NORMALIZE;
            end
        end
    end

    // fixed priority, the same whatever the mask bits say
    always_comb begin
        if (next_flags[`FTE_EX_INV]) begin
            next_top = fte_pkg::TOP_INV;
        end else if (next_flags[`FTE_EX_DEN]) begin
            next_top = fte_pkg::TOP_DEN;
        end else if (next_flags[`FTE_EX_OVF]) begin
            next_top = fte_pkg::TOP_OVF;
        end else if (next_flags[`FTE_EX_UNF]) begin
            next_top = fte_pkg::TOP_UNF;
        end else if (next_flags[`FTE_EX_PRE]) begin
            next_top = fte_pkg::TOP_PRE;
        end else begin
            next_top = fte_pkg::TOP_NONE;
        end
    end

    // exception outputs, one pulse per executed isArith instruction (not for env load/store or nop)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            excValid <= 1'b0;
            excFlags <= 5'h00;
            excTop <= fte_pkg::TOP_NONE;
            resultSel <= fte_pkg::RES_NORMAL;
            roundPrec <= `FTE_PC_EXT;
            expAdjust <= 1'b0;
            lastResp <= 32'h0000_0000;
        end else begin
            excValid <= opValid && isArith;
            excFlags <= opValid ? next_flags : 5'h00;
            if (opValid && isArith) begin
                excTop <= next_top;
                resultSel <= next_res;
                roundPrec <= next_prec;
                expAdjust <= next_expAdj;
                lastResp <= {16'h0000, 1'b0, next_top, next_expAdj,
                    next_res, next_prec, 1'b0, next_flags};
            end
        end
    end

    // sticky status: a new event wins over a write-one clear
    always_comb begin
        next_status = status;
        next_imask = imask;
        if (wrGo && awAddr == `FTE_OFF_STATUS) begin
            next_status = status & ~strobeMerge(32'h0, wData, wStrb);
        end
        if (wrGo && awAddr == `FTE_OFF_IMASK) begin
            next_imask = strobeMerge(imask, wData, wStrb) & 32'h1f;
        end
        if (opValid) begin
            next_status[4:0] = next_status[4:0] | next_flags;
        end
    end

    // status, interrupt mask and the level interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= 32'h0000_0000;
            imask <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            imask <= next_imask;
            irq <= |(next_status & next_imask);
        end
    end

    // control register: masks, precision and rounding fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `FTE_CTRL_RST;
        end else if (wrGo && awAddr == `FTE_OFF_CTRL) begin
            ctrl <= strobeMerge(ctrl, wData, wStrb) & 32'h0000_0f1f;
        end
    end

    // write channels: address and data taken in either order
    assign wrGo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awAddr <= 12'h000;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
            if (wrGo) begin
                s_axi_bvalid <= 1'b1;
                // tag word and last response are read-only
                s_axi_bresp <= (awAddr == `FTE_OFF_CTRL
                    || awAddr == `FTE_OFF_STATUS
                    || awAddr == `FTE_OFF_IMASK) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: data latched at the address handshake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (s_axi_araddr == `FTE_OFF_CTRL) begin
                s_axi_rdata <= ctrl;
            end else if (s_axi_araddr == `FTE_OFF_STATUS) begin
                s_axi_rdata <= status;
            end else if (s_axi_araddr == `FTE_OFF_IMASK) begin
                s_axi_rdata <= imask;
            end else if (s_axi_araddr == `FTE_OFF_TAGW) begin
                s_axi_rdata <= {16'h0000, liveTagWord};
            end else if (s_axi_araddr == `FTE_OFF_LAST) begin
                s_axi_rdata <= lastResp;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks on the decisions above
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_load_empty: assert property (opValid && opCode == fte_pkg::OP_ENV_LOAD
        && tagWordIn[1:0] == 2'h3 |=> emptyMask[0])
        else $error("tag 11 did not mark register empty");
    a_load_nonempty: assert property (opValid
        && opCode == fte_pkg::OP_ENV_LOAD && tagWordIn[1:0] == 2'h2
        |=> !emptyMask[0])
        else $error("tag 10 did not mark register non-empty");
    a_store_tag: assert property (opValid && opCode == fte_pkg::OP_ENV_STORE
        && !emptyMask[0] |=> tagWordValid
        && tagWordOut[1:0] == $past(clsTag[0]))
        else $error("stored tag does not follow contents");
    a_signaling_nan_inv: assert property (opValid && isArith && anySnan
        |=> excValid && excFlags[0])
        else $error("signaling nan without invalid");
    a_quiet_nan_quiet: assert property (opValid && opCode == fte_pkg::OP_ARITH
        && anyQnan && !anySnan && !anyUns
        |=> !excFlags[0] && resultSel == fte_pkg::RES_QUIET_NAN)
        else $error("quiet nan raised invalid");
    a_unsupp_inv: assert property (opValid && opCode == fte_pkg::OP_ARITH
        && anyUns |=> excFlags[0])
        else $error("unsupported operand without invalid");
    a_chop_max: assert property (opValid && opCode == fte_pkg::OP_ARITH
        && resOverflow && !anyQnan && !anyUns && !anySnan && !anyDen
        && ctrl[2] && ctrl[11:10] == 2'h3
        |=> resultSel == fte_pkg::RES_MAXFIN)
        else $error("chop overflow did not give largest finite");
    a_ovf_prec: assert property (opValid && isArith && resOverflow
        && !ctrl[2] |=> excFlags[4] && excFlags[2])
        else $error("unmasked overflow without precision");
    a_unf_masked: assert property (opValid && ctrl[3] && resTiny
        && !resInexact |=> !excFlags[3])
        else $error("masked exact tiny result signaled underflow");
    a_den_prio: assert property (excValid && excFlags[1] && !excFlags[0]
        |-> excTop == fte_pkg::TOP_DEN)
        else $error("denormal lost its priority");
    a_irq_level: assert property (irq == |(status & imask))
        else $error("interrupt does not follow status and mask");
    c_env_store: cover property (opValid
        && opCode == fte_pkg::OP_ENV_STORE);
    c_normalize: cover property (resultSel == fte_pkg::RES_NORMALIZE);
    c_unf_round: cover property (expAdjust);
endmodule : fte_unit

// file: sim/fte_host.sv
// host pipeline model: loads stack registers and issues instructions
// assumes the unit samples every input on the rising edge of clk
module fte_host (
    input wire logic clk,
    output logic regWrEn,
    output logic [2:0] regWrIdx,
    output logic [79:0] regWrData,
    output logic opValid,
    output fte_pkg::fte_op_t opCode,
    output logic [2:0] opRegA,
    output logic [15:0] tagWordIn,
    output logic opPcControlled,
    output logic [1:0] opPrec,
    output logic resOverflow,
    output logic resTiny,
    output logic resInexact
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle state at time zero
    initial begin
        regWrEn = 1'h0;
        regWrIdx = 3'h0;
        regWrData = '1;
        opValid = 1'h0;
        opCode = fte_pkg::OP_NOP;
        opRegA = 3'h0;
        tagWordIn = 16'h5555;
        {opPcControlled, opPrec, resOverflow, resTiny, resInexact} = 6'h0;
    end
    // one register write, then the data bus shows junk, not the last word
    task automatic put(input logic [2:0] i, input logic [79:0] v);
        @(posedge clk);
        regWrEn <= 1'h1;
        regWrIdx <= i;
        regWrData <= v;
        @(posedge clk);
        regWrEn <= 1'h0;
        regWrData <= ~v;
    endtask : put
    // one instruction; c = {pcControlled, prec[1:0], ovf, tiny, inexact}
    task automatic issue(input fte_pkg::fte_op_t op, input logic [2:0] a,
            input logic [15:0] tw, input logic [5:0] c);
        @(posedge clk);
        opValid <= 1'h1;
        opCode <= op;
        opRegA <= a;
        tagWordIn <= tw;
        {opPcControlled, opPrec, resOverflow, resTiny, resInexact} <= c;
        @(posedge clk);
        opValid <= 1'h0;
        opCode <= fte_pkg::OP_NOP;
        tagWordIn <= ~tw;
        {resOverflow, resTiny, resInexact} <= ~c[2:0];
    endtask : issue
endmodule : fte_host

// file: sim/fte_unit_tb.sv
// self-checking bench for the tag and exception unit
// assumes fte_host drives the instruction port; registers over AXI4-Lite
`include "fte_defs.svh"
module fte_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, regWrEn, opValid;
    logic [1:0] s_axi_bresp, s_axi_rresp, opPrec, roundPrec, rr, br;
    logic opPcControlled, resOverflow, resTiny, resInexact, irq;
    logic tagWordValid, excValid, expAdjust;
    logic [2:0] regWrIdx, opRegA;
    logic [79:0] regWrData;
    logic [15:0] tagWordIn, tagWordOut;
    logic [4:0] excFlags;
    fte_pkg::fte_op_t opCode;
    fte_pkg::fte_top_t excTop;
    fte_pkg::fte_res_t resultSel;
    int errors = 0;
    int n_compared = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    fte_unit i_fte_unit (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .regWrEn, .regWrIdx,
        .regWrData, .opValid, .opCode, .opRegA, .opRegB(3'h0),
        .opUsesB(1'h0), .opPcControlled, .opPrec, .tagWordIn, .resOverflow,
        .resTiny, .resInexact, .tagWordOut, .tagWordValid, .excValid,
        .excFlags, .excTop, .resultSel, .roundPrec, .expAdjust, .irq);
    fte_host i_fte_host (.clk, .regWrEn, .regWrIdx, .regWrData, .opValid,
        .opCode, .opRegA, .tagWordIn, .opPcControlled, .opPrec,
        .resOverflow, .resTiny, .resInexact);
    task automatic chk(input string w, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    // each channel released at the edge that takes it
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) {s_axi_bready, br} <= {1'h0, s_axi_bresp};
        end while (s_axi_bready);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'h0;
                rd = s_axi_rdata;
                rr = s_axi_rresp;
            end
        end while (s_axi_rready);
    endtask : axi_rd
    // r: result code 0 normal,1 none,2 quiet_nan,3 normalize,4 max,5 inf; 8 skip
    task automatic op_chk(input string w, input fte_pkg::fte_op_t op,
            input logic [2:0] a, input logic [5:0] c, input logic [4:0] f,
            input logic [3:0] r);
        i_fte_host.issue(op, a, 16'h0, c);
        #1;
        chk({w, " valid"}, excValid, 1'h1);
        chk({w, " flags"}, excFlags, f);
        if (!r[3]) chk({w, " result"}, resultSel, r[2:0]);
    endtask : op_chk
    task automatic env(input logic [15:0] e);
        i_fte_host.issue(fte_pkg::OP_ENV_STORE, 3'h0, 16'h0, 6'h0);
        #1;
        chk("tag valid", tagWordValid, 1'h1);
        chk("tag word", tagWordOut, e);
    endtask : env
    // regs: normal, zero, denormal, unnormal, signaling_nan, quiet_nan
    task automatic t_tags();
        logic [79:0] v [6] = '{80'h3fff_8000_0000_0000_0000, 80'h0, 80'h1,
            80'h3fff_4000_0000_0000_0000, 80'h7fff_a000_0000_0000_0000,
            80'h7fff_c000_0000_0000_0000};
        chk("reset tags", tagWordOut, 16'hffff);
        axi_rd(`FTE_OFF_CTRL);
        chk("ctrl reset", rd, `FTE_CTRL_RST);
        for (int i = 0; i < 6; i++) i_fte_host.put(3'(i), v[i]);
        env(16'hfaa4);
        // load a tag word that lies about reg0 and empties reg1
        i_fte_host.issue(fte_pkg::OP_ENV_LOAD, 3'h0, 16'hf00e, 6'h0);
        env(16'hfaac);
        op_chk("lied", fte_pkg::OP_ARITH, 3'h0, 6'h0, 5'h0, 4'h0);
    endtask : t_tags
    task automatic t_ops();
        fte_pkg::fte_op_t ops [3] = '{fte_pkg::OP_COMPARE,
            fte_pkg::OP_INT_STORE, fte_pkg::OP_BCD_STORE};
        op_chk("signaling_nan", fte_pkg::OP_ARITH, 3'h4, 6'h0, 5'h1, 4'h2);
        op_chk("quiet_nan", fte_pkg::OP_ARITH, 3'h5, 6'h0, 5'h0, 4'h2);
        foreach (ops[i]) op_chk("qst", ops[i], 5, 0, 1, 8);
        op_chk("unn", fte_pkg::OP_ARITH, 3'h3, 6'h0, 5'h1, 4'h8);
        op_chk("dtr", fte_pkg::OP_TRANSC, 3'h2, 6'h0, 5'h2, 4'h3);
        chk("den top", excTop, fte_pkg::TOP_DEN);
        op_chk("dex", fte_pkg::OP_EXTRACT, 3'h2, 6'h0, 5'h2, 4'h3);
        axi_wr(`FTE_OFF_CTRL, 32'h31d);
        op_chk("dun", fte_pkg::OP_TRANSC, 3'h2, 6'h0, 5'h2, 4'h1);
        chk("den top", excTop, fte_pkg::TOP_DEN);
        // overflow: chop, nearest, then unmasked with precision field 1
        axi_wr(`FTE_OFF_CTRL, 32'hf1f);
        op_chk("och", fte_pkg::OP_ARITH, 0, 6'h05, 5'h14, 4'h4);
        axi_wr(`FTE_OFF_CTRL, 32'h31f);
        op_chk("onr", fte_pkg::OP_ARITH, 0, 6'h05, 5'h14, 4'h5);
        axi_wr(`FTE_OFF_CTRL, 32'h11b);
        op_chk("oun", fte_pkg::OP_ARITH, 0, 6'h14, 5'h14, 4'h8);
        chk("ovf opcode prec", roundPrec, 2'h2);
        op_chk("opc", fte_pkg::OP_ARITH, 0, 6'h34, 5'h14, 4'h8);
        chk("ovf pc prec", roundPrec, 2'h1);
        // underflow masked, then unmasked with precision field 2
        axi_wr(`FTE_OFF_CTRL, 32'h31f);
        op_chk("uex", fte_pkg::OP_ARITH, 0, 6'h02, 5'h00, 4'h8);
        op_chk("uin", fte_pkg::OP_ARITH, 0, 6'h03, 5'h18, 4'h8);
        axi_wr(`FTE_OFF_CTRL, 32'h217);
        op_chk("uun", fte_pkg::OP_ARITH, 0, 6'h02, 5'h08, 4'h8);
        chk("unf ext prec", roundPrec, 2'h3);
        chk("unf adjust", expAdjust, 1'h1);
        op_chk("upc", fte_pkg::OP_ARITH, 0, 6'h22, 5'h08, 4'h8);
        chk("unf pc prec", roundPrec, 2'h2);
    endtask : t_ops
    // interrupt: masked, raised, cleared; then an unmapped read
    task automatic t_irq();
        axi_wr(`FTE_OFF_STATUS, 32'h1f);
        axi_wr(`FTE_OFF_IMASK, 32'h2);
        op_chk("msk", fte_pkg::OP_ARITH, 3'h4, 6'h0, 5'h1, 4'h8);
        chk("irq masked", irq, 1'h0);
        axi_rd(`FTE_OFF_STATUS);
        chk("status", rd, 32'h1);
        axi_wr(`FTE_OFF_IMASK, 32'h1);
        chk("irq raised", irq, 1'h1);
        axi_wr(`FTE_OFF_STATUS, 32'h1);
        chk("bresp", br, 2'h0);
        chk("irq cleared", irq, 1'h0);
        axi_rd(12'h100);
        chk("unmapped resp", rr, 2'h2);
    endtask : t_irq
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_tags();
        t_ops();
        t_irq();
        print_verdict();
    end
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : fte_unit_tb
